// *** hw/mpc_pkg.sv ***
// Package of constants and types for the modem power and channel plan block
package mpc_pkg;

    // ***********************************************
    // Register offsets of the plain register port
    // ***********************************************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CHCFG = 4'h1;
    localparam logic [3:0] ADDR_BAND = 4'h2;
    localparam logic [3:0] ADDR_TEMPCH = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_CHAN = 4'h5;
    localparam logic [3:0] ADDR_FREQ = 4'h6;
    localparam logic [3:0] ADDR_CMD = 4'h7;

    // ***********************************************
    // Field positions and reset values
    // ***********************************************
    localparam int CFG_METHOD_LSB = 5;
    localparam logic [7:0] CHCFG_RST = 8'hA0;
    localparam logic [2:0] BAND_RST = 3'h0;
    localparam int CMD_RF_OFF = 0;
    localparam int CMD_RF_ON = 1;
    localparam int CMD_DOZE = 2;
    localparam int CMD_TX = 3;
    localparam int CMD_TEMPCH = 4;
    localparam int CMD_TEMPCLR = 5;

    // ***********************************************
    // Channel plan figures
    // ***********************************************
    localparam int NUM_CH = 24;
    localparam logic [11:0] BASE_2M_A = 12'd2433;
    localparam logic [11:0] BASE_2M_B = 12'd2420;
    localparam logic [11:0] BASE_2M_C = 12'd2423;
    localparam logic [11:0] BASE_1M_A = 12'd2426;
    localparam logic [11:0] BASE_1M_B = 12'd2450;

    // ***********************************************
    // Timing
    // ***********************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int POR_MS = 220;
    localparam int WAKE_MS = 75;
    localparam int POR_CYC = POR_MS * (CLK_HZ / 1000);
    localparam int WAKE_CYC = WAKE_MS * (CLK_HZ / 1000);
    localparam int RX_HOP_DIV = 4;

    // ***********************************************
    // Types
    // ***********************************************
    typedef enum logic [2:0] {
        MPC_INIT = 3'b000,
        MPC_ACTIVE = 3'b001,
        MPC_DOZE = 3'b010,
        MPC_RFOFF = 3'b011,
        MPC_SHUT = 3'b100
    } mpc_state_t;

endpackage

// *** hw/mpc_chan_map.sv ***
// Frequency number to carrier frequency mapping
`timescale 1ns/1ps
module mpc_chan_map (
    // Selection
    input wire logic [2:0] band,
    input wire logic [4:0] chan,
    // Result in MHz
    output logic [11:0] freq_mhz
);
    logic [11:0] n12;

    assign n12 = {7'h00, chan};

    always_comb begin
        unique case (band)
            3'h0: freq_mhz = mpc_pkg::BASE_2M_A + (n12 << 1);
            3'h1: freq_mhz = mpc_pkg::BASE_1M_A + n12;
            3'h2: freq_mhz = mpc_pkg::BASE_1M_B + n12;
            3'h3: freq_mhz = mpc_pkg::BASE_2M_B + (n12 << 1);
            3'h4: freq_mhz = mpc_pkg::BASE_2M_C + (n12 << 1);
            default: freq_mhz = mpc_pkg::BASE_2M_A + (n12 << 1);
        endcase
    end
endmodule

// *** hw/mpc_hop.sv ***
// Channel stepper walking one frequency group
`timescale 1ns/1ps
module mpc_hop (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Control
    input wire logic restart,
    input wire logic step,
    input wire logic [4:0] group,
    input wire logic [4:0] ngroups,
    // Current frequency number
    output logic [4:0] chan
);
    logic [5:0] sum;

    assign sum = {1'b0, chan} + {1'b0, ngroups};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chan <= 5'h00;
        end else if (restart) begin
            chan <= group;
        end else if (step) begin
            // Members are g, g+N, g+2N... below 24
            if (sum >= 6'(mpc_pkg::NUM_CH)) begin
                chan <= group;
            end else begin
                chan <= sum[4:0];
            end
        end
    end
endmodule

// *** hw/mpc_top.sv ***
// Power state and channel plan control of the serial radio modem
// Notes on behaviour
// - After power-up and initialisation the block sits in the active state.
// - Doze listens intermittently; a wake-up packet returns it to active.
// - RF-off command enters RF power-down; RF-on command returns to active.
// - In RF power-down registers keep values and stay readable and writable.
// - Shutdown pin low stops everything; high releases shutdown.
// - Leaving shutdown resets temporary settings; stored configuration applies.
// - Commands accepted 220 ms after power-on, 75 ms after shutdown release.
// - Shutdown entered from doze returns to doze on release.
// - Channels are frequency numbers 0 to 23 chosen by band.
// - 2 MHz bands: base 2433, 2420 or 2423 plus 2n MHz.
// - 1 MHz bands: base 2426 or 2450 plus n MHz.
// - Method and group both come from one configuration register.
// - Eight methods: 1x24 up to 24x1; group must be below group count.
// - Single-group method hops over all 24 channels.
// - 24-group method stays on one fixed channel.
// - Multi-channel groups search for a clear channel before linking.
// - Group g of N holds numbers whose remainder modulo N is g.
// - Configuration defaults to group 0 of the eight-group method.
// - Receiver hops slower than transmitter, which hops per retry.
`timescale 1ns/1ps
module mpc_top #(
    parameter int POR_CYCLES = mpc_pkg::POR_CYC,
    parameter int WAKE_CYCLES = mpc_pkg::WAKE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Shutdown pin, low active
    input wire logic shut_n,
    // Radio events
    input wire logic wake_pkt,
    input wire logic listen_tick,
    input wire logic retry,
    input wire logic chan_clear,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Status
    output logic [2:0] state,
    output logic rf_en,
    output logic rx_listen,
    output logic cmd_ready,
    output logic cmd_err,
    output logic tx_go,
    output logic linked,
    output logic [4:0] chan_out,
    output logic [11:0] freq_out
);
    // ***********************************************
    // Declarations
    // ***********************************************
    mpc_pkg::mpc_state_t state_r;
    logic [7:0] chan_group_config_r;
    logic [2:0] band_r;
    logic [4:0] temp_chan_r;
    logic temp_valid_r;
    logic from_doze_r;
    logic [23:0] wait_cnt_r;
    logic cold_r;
    logic [7:0] rdata_r;
    logic cmd_err_r;
    logic tx_go_r;
    logic linked_r;
    logic searching_r;
    logic [1:0] rx_div_r;
    logic [4:0] chan_r;
    logic [11:0] freq_r;
    logic [2:0] method;
    logic [4:0] ngroups;
    logic [4:0] grp_raw;
    logic [4:0] grp;
    logic [4:0] hop_chan;
    logic [4:0] sel_chan;
    logic [11:0] map_freq;
    logic hop_step;
    logic hop_restart;
    logic busy;
    logic cmd_wr;
    logic [7:0] cfg_wd;

    // ***********************************************
    // Method decode
    // ***********************************************
    assign method = chan_group_config_r[7:mpc_pkg::CFG_METHOD_LSB];
    assign grp_raw = chan_group_config_r[4:0];

    always_comb begin
        unique case (method)
            3'h0: ngroups = 5'd1;
            3'h1: ngroups = 5'd2;
            3'h2: ngroups = 5'd3;
            3'h3: ngroups = 5'd4;
            3'h4: ngroups = 5'd6;
            3'h5: ngroups = 5'd8;
            3'h6: ngroups = 5'd12;
            3'h7: ngroups = 5'd24;
        endcase
    end

    // Clamp a written group to the method's range
    always_comb begin
        cfg_wd = wdata;
        unique case (wdata[7:5])
            3'h0: cfg_wd[4:0] = 5'd0;
            3'h1: cfg_wd[4:0] = (wdata[4:0] > 5'd1) ? 5'd1 : wdata[4:0];
            3'h2: cfg_wd[4:0] = (wdata[4:0] > 5'd2) ? 5'd2 : wdata[4:0];
            3'h3: cfg_wd[4:0] = (wdata[4:0] > 5'd3) ? 5'd3 : wdata[4:0];
            3'h4: cfg_wd[4:0] = (wdata[4:0] > 5'd5) ? 5'd5 : wdata[4:0];
            3'h5: cfg_wd[4:0] = (wdata[4:0] > 5'd7) ? 5'd7 : wdata[4:0];
            3'h6: cfg_wd[4:0] = (wdata[4:0] > 5'd11) ? 5'd11 : wdata[4:0];
            3'h7: cfg_wd[4:0] = (wdata[4:0] > 5'd23) ? 5'd23 : wdata[4:0];
        endcase
    end

    // A config write restarts the hop on the group being written
    assign grp = (wr && !busy && addr == mpc_pkg::ADDR_CHCFG)
        ? cfg_wd[4:0] : grp_raw;
    assign busy = (state_r == mpc_pkg::MPC_INIT)
        || (state_r == mpc_pkg::MPC_SHUT);
    assign cmd_wr = wr && (addr == mpc_pkg::ADDR_CMD) && !busy;

    // ***********************************************
    // Power state machine
    // ***********************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= mpc_pkg::MPC_INIT;
        end else if (!shut_n) begin
            state_r <= mpc_pkg::MPC_SHUT;
        end else begin
            unique case (state_r)
                mpc_pkg::MPC_INIT: begin
                    if (wait_cnt_r == 24'h000000) begin
                        if (from_doze_r) begin
                            state_r <= mpc_pkg::MPC_DOZE;
                        end else begin
                            state_r <= mpc_pkg::MPC_ACTIVE;
                        end
                    end
                end
                mpc_pkg::MPC_ACTIVE: begin
                    if (cmd_wr && wdata[mpc_pkg::CMD_RF_OFF]) begin
                        state_r <= mpc_pkg::MPC_RFOFF;
                    end else if (cmd_wr && wdata[mpc_pkg::CMD_DOZE]) begin
                        state_r <= mpc_pkg::MPC_DOZE;
                    end
                end
                mpc_pkg::MPC_DOZE: begin
                    if (wake_pkt) begin
                        state_r <= mpc_pkg::MPC_ACTIVE;
                    end
                end
                mpc_pkg::MPC_RFOFF: begin
                    if (cmd_wr && wdata[mpc_pkg::CMD_RF_ON]) begin
                        state_r <= mpc_pkg::MPC_ACTIVE;
                    end
                end
                mpc_pkg::MPC_SHUT: begin
                    state_r <= mpc_pkg::MPC_INIT;
                end
                default: state_r <= mpc_pkg::MPC_INIT;
            endcase
        end
    end

    // Remember doze across shutdown
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            from_doze_r <= 1'b0;
        end else if (!shut_n && state_r != mpc_pkg::MPC_SHUT
                && state_r != mpc_pkg::MPC_INIT) begin
            from_doze_r <= (state_r == mpc_pkg::MPC_DOZE);
        end else if (state_r == mpc_pkg::MPC_ACTIVE
                || state_r == mpc_pkg::MPC_RFOFF) begin
            from_doze_r <= 1'b0;
        end
    end

    // ***********************************************
    // Initialisation timer
    // ***********************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_cnt_r <= 24'(mpc_pkg::POR_CYC - 1);
            cold_r <= 1'b1;
        end else if (!shut_n) begin
            wait_cnt_r <= 24'(WAKE_CYCLES - 1);
            cold_r <= 1'b0;
        end else if (state_r == mpc_pkg::MPC_INIT) begin
            if (cold_r && wait_cnt_r > 24'(POR_CYCLES - 1)) begin
                wait_cnt_r <= 24'(POR_CYCLES - 1);
            end else if (wait_cnt_r != 24'h000000) begin
                wait_cnt_r <= wait_cnt_r - 24'h000001;
            end
        end
    end

    // ***********************************************
    // Configuration registers
    // ***********************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chan_group_config_r <= mpc_pkg::CHCFG_RST;
            band_r <= mpc_pkg::BAND_RST;
        end else if (wr && !busy) begin
            // Writable in every running state, RF off included
            if (addr == mpc_pkg::ADDR_CHCFG) begin
                chan_group_config_r <= cfg_wd;
            end
            if (addr == mpc_pkg::ADDR_BAND && wdata[2:0] <= 3'h4) begin
                band_r <= wdata[2:0];
            end
        end
    end

    // Temporary channel, lost on shutdown
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            temp_chan_r <= 5'h00;
            temp_valid_r <= 1'b0;
        end else if (!shut_n) begin
            temp_valid_r <= 1'b0;
        end else if (wr && !busy && addr == mpc_pkg::ADDR_TEMPCH
                && wdata[4:0] < 5'(mpc_pkg::NUM_CH)) begin
            temp_chan_r <= wdata[4:0];
        end else if (cmd_wr && wdata[mpc_pkg::CMD_TEMPCLR]) begin
            temp_valid_r <= 1'b0;
        end else if (cmd_wr && wdata[mpc_pkg::CMD_TEMPCH]) begin
            temp_valid_r <= 1'b1;
        end
    end

    // ***********************************************
    // Command answers
    // ***********************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_err_r <= 1'b0;
            tx_go_r <= 1'b0;
        end else begin
            cmd_err_r <= cmd_wr && wdata[mpc_pkg::CMD_TX]
                && state_r != mpc_pkg::MPC_ACTIVE;
            tx_go_r <= cmd_wr && wdata[mpc_pkg::CMD_TX]
                && state_r == mpc_pkg::MPC_ACTIVE;
        end
    end

    // ***********************************************
    // Channel search
    // ***********************************************
    // Receiver steps on every RX_HOP_DIV-th listen tick
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_div_r <= 2'h0;
        end else if (listen_tick) begin
            rx_div_r <= rx_div_r + 2'h1;
        end
    end

    assign hop_step = (ngroups != 5'd24) && !linked_r
        && (retry || (listen_tick && rx_div_r == 2'(mpc_pkg::RX_HOP_DIV - 1)));
    assign hop_restart = (state_r != mpc_pkg::MPC_ACTIVE)
        || (wr && addr == mpc_pkg::ADDR_CHCFG);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            searching_r <= 1'b0;
            linked_r <= 1'b0;
        end else if (hop_restart) begin
            searching_r <= 1'b0;
            linked_r <= 1'b0;
        end else if (!linked_r) begin
            searching_r <= ngroups != 5'd24;
            linked_r <= chan_clear;
        end
    end

    mpc_hop u_hop (
        .clk(clk),
        .arst_n(arst_n),
        .restart(hop_restart),
        .step(hop_step),
        .group(grp),
        .ngroups(ngroups),
        .chan(hop_chan)
    );

    assign sel_chan = temp_valid_r ? temp_chan_r : hop_chan;

    mpc_chan_map u_map (
        .band(band_r),
        .chan(sel_chan),
        .freq_mhz(map_freq)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chan_r <= 5'h00;
            freq_r <= 12'h000;
        end else begin
            chan_r <= sel_chan;
            freq_r <= map_freq;
        end
    end

    // ***********************************************
    // Register read port
    // ***********************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= 8'h00;
        end else if (rd && !busy) begin
            unique case (addr)
                mpc_pkg::ADDR_CHCFG: rdata_r <= chan_group_config_r;
                mpc_pkg::ADDR_BAND: rdata_r <= {5'h00, band_r};
                mpc_pkg::ADDR_TEMPCH: rdata_r <= {temp_valid_r, 2'h0,
                    temp_chan_r};
                mpc_pkg::ADDR_STATUS: rdata_r <= {3'h0, linked_r,
                    searching_r, state_r};
                mpc_pkg::ADDR_CHAN: rdata_r <= {3'h0, chan_r};
                mpc_pkg::ADDR_FREQ: rdata_r <= freq_r[7:0];
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // ***********************************************
    // Outputs
    // ***********************************************
    assign rdata = rdata_r;
    assign state = state_r;
    assign rf_en = state_r == mpc_pkg::MPC_ACTIVE;
    assign rx_listen = state_r == mpc_pkg::MPC_DOZE;
    assign cmd_ready = !busy;
    assign cmd_err = cmd_err_r;
    assign tx_go = tx_go_r;
    assign linked = linked_r;
    assign chan_out = chan_r;
    assign freq_out = freq_r;
endmodule

// *** dv/mpc_top_sva.sv ***
// Assertion checker for the modem power and channel plan block
`timescale 1ns/1ps
module mpc_top_sva #(
    parameter int POR_CYCLES = 20,
    parameter int WAKE_CYCLES = 10
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Pin and radio events
    input wire logic shut_n,
    input wire logic wake_pkt,
    input wire logic listen_tick,
    input wire logic retry,
    input wire logic chan_clear,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // Status
    input wire logic [2:0] state,
    input wire logic rf_en,
    input wire logic rx_listen,
    input wire logic cmd_ready,
    input wire logic cmd_err,
    input wire logic tx_go,
    input wire logic linked,
    input wire logic [4:0] chan_out,
    input wire logic [11:0] freq_out
);
    logic [31:0] init_cnt_r;
    logic cmd_wr;

    // Cycles spent so far in the start-up state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            init_cnt_r <= 32'h0;
        end else if (state == 3'h0) begin
            init_cnt_r <= init_cnt_r + 32'h1;
        end else begin
            init_cnt_r <= 32'h0;
        end
    end
    assign cmd_wr = shut_n && wr && cmd_ready && addr == 4'h7;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_shut_enter: assert property (!shut_n |=> state == 3'h4)
        else $error("shutdown pin low did not stop the block");
    a_shut_leave: assert property (shut_n && state == 3'h4 |=> state == 3'h0)
        else $error("shutdown release did not restart the block");
    a_init_bound: assert property (state == 3'h0 |-> init_cnt_r <= POR_CYCLES + 2)
        else $error("start-up lasted too long");
    a_ready_decode: assert property (cmd_ready == (state inside {3'h1, 3'h2, 3'h3}))
        else $error("command readiness disagrees with state");
    a_rf_off_go: assert property (cmd_wr && wdata == 8'h01 && state == 3'h1 |=> state == 3'h3 && !rf_en)
        else $error("rf off command not obeyed");
    a_rf_on_back: assert property (cmd_wr && wdata == 8'h02 && state == 3'h3 |=> state == 3'h1 && rf_en)
        else $error("rf on command not obeyed");
    a_doze_wake: assert property (shut_n && !wr && state == 3'h2 && wake_pkt |=> state == 3'h1)
        else $error("wake-up packet did not leave doze");
    a_tx_refuse: assert property (cmd_wr && wdata == 8'h08 |=> cmd_err != tx_go && tx_go == ($past(state) == 3'h1))
        else $error("transmit command answered wrongly");
    a_rfoff_read: assert property (rd && cmd_ready && addr == 4'h4 && state == 3'h3 |=> rdata[2:0] == 3'h3)
        else $error("status not readable in rf power-down");
    a_link_drop: assert property (state != 3'h1 |=> !linked)
        else $error("link held outside the active state");

    c_rf_off: cover property (state == 3'h1 ##1 state == 3'h3);
    c_wake: cover property (state == 3'h2 ##1 state == 3'h1);
    c_shut: cover property (state == 3'h4 ##1 state == 3'h0);
    c_tx: cover property (tx_go);
endmodule

bind mpc_top mpc_top_sva #(.POR_CYCLES(POR_CYCLES),
    .WAKE_CYCLES(WAKE_CYCLES)) u_sva (.clk(clk), .arst_n(arst_n),
    .shut_n(shut_n), .wake_pkt(wake_pkt), .listen_tick(listen_tick),
    .retry(retry), .chan_clear(chan_clear), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .state(state), .rf_en(rf_en),
    .rx_listen(rx_listen), .cmd_ready(cmd_ready), .cmd_err(cmd_err),
    .tx_go(tx_go), .linked(linked), .chan_out(chan_out),
    .freq_out(freq_out));

// *** dv/mpc_term_model.sv ***
// Terminal equipment model driving the register port and shutdown pin
`timescale 1ns/1ps
module mpc_term_model (
    // Clock and device status
    input wire logic clk,
    input wire logic cmd_ready,
    input wire logic [7:0] rdata,
    // Shutdown pin
    output logic shut_n,
    // Register port
    output logic [3:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd
);
    initial begin
        shut_n = 1'b1;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end

    // Holds off requests until the device takes commands
    task automatic wait_ready();
        while (cmd_ready !== 1'b1) @(posedge clk);
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        wait_ready();
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        // Released lines show no stale value
        addr <= ~a;
        wdata <= ~d;
        #1;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        wait_ready();
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask

    task automatic set_shut(input logic lvl);
        @(posedge clk);
        shut_n <= lvl;
        #1;
    endtask
endmodule

// *** dv/tb_modem_power_and_channel_plan.sv ***
// Self-checking testbench of the modem power and channel plan block
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
    mismatches++; $display("wrong value at %0t: got %h exp %h", \
    $time, (g), (e)); end end
module tb_modem_power_and_channel_plan;
    localparam int LIMIT = 20000;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic wake_pkt = 1'b0;
    logic listen_tick = 1'b0;
    logic retry = 1'b0;
    logic chan_clear;
    logic shut_n, wr, rd, rf_en, rx_listen, cmd_ready, cmd_err, tx_go;
    logic linked;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    logic [2:0] state;
    logic [4:0] chan_out;
    logic [11:0] freq_out;
    logic [31:0] rng = 32'h0000_0063;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;

    mpc_top #(.POR_CYCLES(20), .WAKE_CYCLES(10)) dut (.clk(clk),
        .arst_n(arst_n), .shut_n(shut_n), .wake_pkt(wake_pkt),
        .listen_tick(listen_tick), .retry(retry), .chan_clear(chan_clear),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .state(state), .rf_en(rf_en), .rx_listen(rx_listen),
        .cmd_ready(cmd_ready), .cmd_err(cmd_err), .tx_go(tx_go),
        .linked(linked), .chan_out(chan_out), .freq_out(freq_out));
    mpc_term_model u_term (.clk(clk), .cmd_ready(cmd_ready),
        .rdata(rdata), .shut_n(shut_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd));

    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            final_report();
        end
    end

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    // Carrier in MHz for a band code and frequency number
    function automatic logic [11:0] exp_freq(input int b, input int n);
        case (b)
            0: return 12'h981 + 12'(2 * n);
            1: return 12'h97A + 12'(n);
            2: return 12'h992 + 12'(n);
            3: return 12'h974 + 12'(2 * n);
            default: return 12'h977 + 12'(2 * n);
        endcase
    endfunction
    function automatic int ngrp(input int m);
        case (m)
            0: return 1;
            1: return 2;
            2: return 3;
            3: return 4;
            4: return 6;
            5: return 8;
            6: return 12;
            default: return 24;
        endcase
    endfunction
    function automatic logic [7:0] bitv(input int b);
        return 8'h01 << b;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input int which);
        @(posedge clk);
        case (which)
            0: retry <= 1'b1;
            1: listen_tick <= 1'b1;
            default: wake_pkt <= 1'b1;
        endcase
        @(posedge clk);
        retry <= 1'b0;
        listen_tick <= 1'b0;
        wake_pkt <= 1'b0;
        tick(2);
    endtask
    task automatic cmd(input int b);
        u_term.reg_wr(mpc_pkg::ADDR_CMD, bitv(b));
    endtask
    task automatic cfg(input int m, input int g);
        u_term.reg_wr(mpc_pkg::ADDR_CHCFG, {m[2:0], g[4:0]});
        tick(3);
    endtask
    task automatic wait_cnt(output int n);
        n = 0;
        while (cmd_ready !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        logic [7:0] v;
        logic [4:0] prev;
        int n, g, ng;
        chan_clear <= 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        wait_cnt(n);
        `CHK(n >= 19 && n <= 23, 1'b1)
        `CHK(state, 3'h1)
        u_term.reg_rd(mpc_pkg::ADDR_CHCFG, v);
        `CHK(v, 8'hA0)
        u_term.reg_rd(mpc_pkg::ADDR_CTRL, v);
        `CHK(v, 8'h00)
        done("reset");
        for (int b = 0; b < 6; b++) begin
            n = (b == 5) ? 23 : int'(xs() % 24);
            u_term.reg_wr(mpc_pkg::ADDR_BAND, 8'(b % 5));
            cfg(7, n);
            pulse(0);
            `CHK(chan_out, 5'(n))
            if (b % 5 == 1 || b % 5 == 2) begin
                `CHK(freq_out, exp_freq(b % 5, n))
            end else begin
                `CHK(freq_out, exp_freq(b % 5, n))
            end
        end
        u_term.reg_wr(mpc_pkg::ADDR_BAND, 8'h05);
        u_term.reg_rd(mpc_pkg::ADDR_BAND, v);
        `CHK(v[2:0], 3'h0)
        done("bands");
        for (int m = 0; m < 7; m++) begin
            ng = ngrp(m);
            g = int'(xs() % ng);
            cfg(m, g);
            repeat (3) begin
                prev = chan_out;
                pulse(0);
                `CHK(5'(int'(chan_out) % ng), 5'(g))
                `CHK(chan_out != prev, 1'b1)
                `CHK(chan_out < 5'd24, 1'b1)
            end
        end
        cfg(0, 0);
        repeat (23) pulse(0);
        `CHK(chan_out, 5'd23)
        cfg(1, 31);
        pulse(0);
        `CHK(chan_out, 5'd3)
        repeat (3) pulse(1);
        `CHK(chan_out, 5'd3)
        pulse(1);
        `CHK(chan_out, 5'd5)
        done("groups");
        cfg(5, 2);
        chan_clear <= 1'b1;
        n = 0;
        while (linked !== 1'b1 && n < 50) begin
            tick(1);
            n++;
        end
        `CHK(linked, 1'b1)
        chan_clear <= 1'b0;
        cmd(mpc_pkg::CMD_RF_OFF);
        tick(1);
        `CHK({state, rf_en, linked}, 5'b01100)
        cmd(mpc_pkg::CMD_TX);
        `CHK({cmd_err, tx_go}, 2'b10)
        u_term.reg_wr(mpc_pkg::ADDR_CHCFG, 8'h41);
        u_term.reg_rd(mpc_pkg::ADDR_CHCFG, v);
        `CHK(v, 8'h41)
        u_term.reg_rd(mpc_pkg::ADDR_STATUS, v);
        `CHK(v[2:0], 3'h3)
        cmd(mpc_pkg::CMD_RF_ON);
        `CHK({state, rf_en}, 4'b0011)
        cmd(mpc_pkg::CMD_TX);
        `CHK({cmd_err, tx_go}, 2'b01)
        done("rf power-down");
        cfg(7, 3);
        u_term.reg_wr(mpc_pkg::ADDR_TEMPCH, 8'h89);
        cmd(mpc_pkg::CMD_TEMPCH);
        tick(3);
        `CHK(chan_out, 5'd9)
        u_term.set_shut(1'b0);
        tick(1);
        `CHK(state, 3'h4)
        u_term.set_shut(1'b1);
        tick(1);
        `CHK(cmd_ready, 1'b0)
        wait_cnt(n);
        `CHK(n >= 8 && n <= 12, 1'b1)
        tick(3);
        `CHK({state, chan_out}, 8'h23)
        done("shutdown");
        cmd(mpc_pkg::CMD_DOZE);
        `CHK({state, rx_listen, rf_en}, 5'b01010)
        pulse(1);
        `CHK(state, 3'h2)
        pulse(2);
        `CHK(state, 3'h1)
        cmd(mpc_pkg::CMD_DOZE);
        u_term.set_shut(1'b0);
        tick(1);
        u_term.set_shut(1'b1);
        wait_cnt(n);
        `CHK(state, 3'h2)
        done("doze");
        final_report();
    end
endmodule
